// ### test_trigger_readout_pipeline.sv
// Purpose: scenario bench for the readout block
// Assumes: pipe depth shortened to 4; clock enable held high
// Notes: inputs held steady, bar one bcid_i change in t_single, so the pipe output is known
`timescale 1ns/1ps
// ========================================
// bench
module test_trigger_readout_pipeline;
  reg           clk_sys_i       = 1'b0;
  reg           rst_i           = 1'b1;
  reg           level1_accept_i = 1'b0;
  reg  [5:0]    rr_delay_i      = 6'h00;
  reg  [2:0]    rr_length_i     = 3'h1;
  reg  [1055:0] link_data_i     = {96{11'h5A3}};
  reg  [11:0]   bcid_i          = 12'hABC;
  reg  [23:0]   jet_count_i     = 24'h123456;
  reg  [23:0]   energy_sum_i    = 24'h0F0F0F;
  reg  [87:0]   roi_jets_i      = {8{11'h2C5}};
  wire          rp;
  wire [15:0]   ss;
  wire [3:0]    rs;
  wire          sb, rb, so, ro;
  wire [66:0]   w15, w0, wr;
  wire [8:0]    l15, l0, lr;
  wire [7:0]    p15, p0, pr;
  integer       error_cnt = 0;
  integer       cmp_count = 0;
  integer       rq_cnt    = 0;
  trp_readout #(.PIPE_DEPTH(4)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .level1_accept_i(level1_accept_i),
    .rr_delay_i(rr_delay_i), .rr_length_i(rr_length_i), .link_data_i(link_data_i),
    .bcid_i(bcid_i), .jet_count_i(jet_count_i), .energy_sum_i(energy_sum_i),
    .roi_jets_i(roi_jets_i), .readout_request_pulse_o(rp), .slice_serial_o(ss),
    .roi_serial_o(rs), .slice_busy_o(sb), .roi_busy_o(rb), .slice_overflow_o(so),
    .roi_overflow_o(ro));
  trp_collector u_c15 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ser_i(ss[15]), .busy_i(sb),
    .word_o(w15), .len_o(l15), .pkts_o(p15), .fill_o());
  trp_collector u_c0 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ser_i(ss[0]), .busy_i(sb),
    .word_o(w0), .len_o(l0), .pkts_o(p0), .fill_o());
  trp_collector u_cr (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ser_i(rs[0]), .busy_i(rb),
    .word_o(wr), .len_o(lr), .pkts_o(pr), .fill_o());
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (rp === 1'b1) rq_cnt <= rq_cnt + 1;
  task cmp(input [66:0] got, input [66:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task accept(input [5:0] d, input [2:0] n);
    rr_delay_i <= d;
    rr_length_i <= n;
    level1_accept_i <= 1'b1;
    @(posedge clk_sys_i);
    level1_accept_i <= 1'b0;
  endtask
  // bounded wait for 100 quiet ticks; longer than any start latency plus gap
  task settle;
    integer i, q;
    q = 0;
    for (i = 0; i < 40000 && q < 100; i = i + 1) begin
      @(posedge clk_sys_i);
      q = (sb === 1'b0 && rb === 1'b0) ? q + 1 : 0;
    end
    if (q < 100) cmp(67'h1, 67'h0);
  endtask
  task t_single;
    reg [65:0] s;
    reg [43:0] r;
    s = {4'h0, bcid_i, jet_count_i, energy_sum_i, 2'h0};
    r = roi_jets_i[43:0];
    accept(6'h00, 3'h1);
    bcid_i <= 12'h123;
    settle;
    cmp(w15, {~^s, s});
    cmp(w0, {~^link_data_i[65:0], link_data_i[65:0]});
    cmp(wr, {~^r, r});
    cmp({58'h0, l15}, 67'h43);
  endtask
  task t_five;
    integer n, m;
    n = rq_cnt;
    m = pr;
    accept(6'h3F, 3'h5);
    settle;
    cmp(67'(rq_cnt - n), 67'h5);
    cmp({58'h0, l0}, 67'h14F);
    cmp(67'(pr - m), 67'h1);
  endtask
  task t_back;
    integer n;
    n = p15;
    accept(6'h00, 3'h1);
    @(posedge clk_sys_i);
    accept(6'h00, 3'h2);
    settle;
    cmp(67'(p15 - n), 67'h2);
    cmp({58'h0, l15}, 67'h86);
  endtask
  task t_ovf;
    integer i;
    for (i = 0; i < 60; i = i + 1) begin
      accept(6'h00, 3'h5);
      repeat (5) @(posedge clk_sys_i);
    end
    settle;
    cmp({65'h0, so, ro}, 67'h2);
  endtask
  initial begin
    #(60000 * 25);
    $display("ERROR %0t watchdog expired", $time);
    error_cnt = error_cnt + 1;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    cmp({42'h0, rp, ss, rs, sb, rb, so, ro}, 67'h0);
    t_single;
    t_five;
    t_back;
    t_ovf;
    close_out;
  end
endmodule // test_trigger_readout_pipeline

// ### trp_collector.sv
// Purpose: readout collector model on one serial line
// Assumes: one bit per bunch tick while busy is high
// Notes: keeps the first 67 bits; longer packets only show in len_o
`timescale 1ns/1ps
// ========================================
// collector
module trp_collector (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        ser_i,
  input  wire        busy_i,
  output reg  [66:0] word_o,
  output reg  [8:0]  len_o,
  output reg  [7:0]  pkts_o,
  output wire        fill_o
);
  reg [8:0] cnt_q;
  // fill frames whenever no packet bit is on the line
  assign fill_o = !busy_i;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= 9'h000;
      len_o  <= 9'h000;
      pkts_o <= 8'h00;
      word_o <= 67'h0;
    end else if (busy_i) begin
      if (cnt_q < 9'h043) word_o[cnt_q] <= ser_i;
      cnt_q <= cnt_q + 9'h001;
    end else if (cnt_q != 9'h000) begin
      len_o  <= cnt_q;
      pkts_o <= pkts_o + 8'h01;
      cnt_q  <= 9'h000;
    end
  end
endmodule // trp_collector

// ### trp_map.vh
// Purpose: constants for the trigger readout pipeline
// Assumes: one 40 MHz bunch clock, synchronous active-high reset
// Notes: slice and region-of-interest framing figures
//
// Notes on behaviour
// - delay captured data about 48 ticks
// - read request follows accept after 0-63 ticks
// - read request lasts 1 to 5 ticks
// - copy 1-5 slice words, one roi word
// - slice readout on 16 serial streams
// - roi stream two bits, four on forward
// - empty fifos: transmit new event at once
// - send packets until all fifos drained
// - at least one separator bit between packets
// - inter-packet gap is 20 ticks
// - slice packet 67 bits per slice
// - roi packet exactly 45 bits
// - capture 24 link words of 11 bits
// - record 12-bit bunch crossing identifier
// - capture jet count and energy with parity; code takes 24 bits of each and no parity bits
// - capture 8 jets of 11 bits
// - neighbour duplicate data is not captured
// - serial streams one bit at bunch rate
`ifndef TRP_MAP_VH
`define TRP_MAP_VH
`define TRP_PIPE_DEPTH    48
`define TRP_DELAY_W       6
`define TRP_LEN_W         3
`define TRP_LEN_MAX       3'h5
`define TRP_FIFO_DEPTH    256
`define TRP_FIFO_AW       8
`define TRP_LINK_CH       24
`define TRP_LINK_W        11
`define TRP_BCID_W        12
`define TRP_RES_W         25
`define TRP_JET_N         8
`define TRP_JET_W         11
`define TRP_SLICE_BITS    67
`define TRP_SLICE_PAY     66
`define TRP_ROI_BITS      45
`define TRP_ROI_PAY       44
`define TRP_STREAMS       16
`define TRP_GAP_TICKS     20
`define TRP_CNT_W         8
`endif

// ### trp_readout.v
// Purpose: fixed-latency readout pipeline, derandomiser and packet serialiser
// Assumes: all inputs come from logic on the bunch clock; no registers
// Notes: neighbour copies never enter here, so the pipe holds only own data
`timescale 1ns/1ps
`include "trp_map.vh"
module trp_readout #(
  parameter PIPE_DEPTH = `TRP_PIPE_DEPTH,
  parameter FIFO_AW    = `TRP_FIFO_AW,
  parameter GAP_TICKS  = `TRP_GAP_TICKS,
  parameter FCAL       = 0
) (
  input  wire                                  clk_sys_i,
  input  wire                                  rst_i,
  input  wire                                  ce_i,
  input  wire                                  level1_accept_i,
  input  wire [`TRP_DELAY_W-1:0]               rr_delay_i,
  input  wire [`TRP_LEN_W-1:0]                 rr_length_i,
  input  wire [4*`TRP_LINK_CH*`TRP_LINK_W-1:0] link_data_i,
  input  wire [`TRP_BCID_W-1:0]                bcid_i,
  input  wire [`TRP_RES_W-2:0]                 jet_count_i,
  input  wire [`TRP_RES_W-2:0]                 energy_sum_i,
  input  wire [`TRP_JET_N*`TRP_JET_W-1:0]      roi_jets_i,
  output wire                                  readout_request_pulse_o,
  output reg  [`TRP_STREAMS-1:0]               slice_serial_o,
  output reg  [3:0]                            roi_serial_o,
  output reg                                   slice_busy_o,
  output reg                                   roi_busy_o,
  output reg                                   slice_overflow_o,
  output reg                                   roi_overflow_o
);
  // ==========================================================
  // widths
  localparam LW    = `TRP_LINK_W;
  localparam SW    = `TRP_STREAMS * `TRP_SLICE_PAY;
  localparam RW    = `TRP_JET_N * `TRP_JET_W;
  localparam ROIL  = FCAL ? 4 : 2;
  localparam ROIPW = ROIL * `TRP_ROI_PAY;
  localparam DEP   = 1 << FIFO_AW;
  localparam [FIFO_AW:0] DEP_N = DEP;
  localparam S_IDLE = 2'h0;
  localparam S_SEND = 2'h1;
  localparam S_GAP  = 2'h2;

  // odd parity: parity bit makes total count of ones odd
  function odd_par;
    input [SW-1:0] v;
    begin
      odd_par = ~(^v);
    end
  endfunction

  // ==========================================================
  // capture and fixed latency pipeline
  // stream map: 4 per processor R,S,T, 3 for U, 1 for results and bcid
  wire [SW-1:0] slice_in;
  wire [ROIPW-1:0] roi_in;
  genvar g;
  generate
    for (g = 0; g < 15; g = g + 1) begin : g_lnk
      // six 11-bit link words per stream (U has 18 on 3 streams, 6 spare)
      assign slice_in[g*`TRP_SLICE_PAY +: `TRP_SLICE_PAY] =
        link_data_i[g*6*LW +: 6*LW];
    end
  endgenerate
  assign slice_in[15*`TRP_SLICE_PAY +: `TRP_SLICE_PAY] =
    {4'h0, bcid_i, jet_count_i, energy_sum_i, 2'h0};
  // a zero-width pad is illegal, so the pad only exists on forward modules
  generate
    if (ROIPW > RW) begin : g_roi_pad
      assign roi_in = {{(ROIPW-RW){1'b0}}, roi_jets_i};
    end else begin : g_roi_nopad
      assign roi_in = roi_jets_i;
    end
  endgenerate

  reg [SW-1:0]    spipe_q [0:PIPE_DEPTH-1];
  reg [ROIPW-1:0] rpipe_q [0:PIPE_DEPTH-1];
  integer i;
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      spipe_q[0] <= slice_in;
      rpipe_q[0] <= roi_in;
      for (i = 1; i < PIPE_DEPTH; i = i + 1) begin
        spipe_q[i] <= spipe_q[i-1];
        rpipe_q[i] <= rpipe_q[i-1];
      end
    end
  end
  wire [SW-1:0]    spipe_out = spipe_q[PIPE_DEPTH-1];
  wire [ROIPW-1:0] rpipe_out = rpipe_q[PIPE_DEPTH-1];

  // ==========================================================
  // read request: delay line of accepts, then stretch
  reg [63:0]            acc_sr_q;
  reg [`TRP_LEN_W-1:0]  rr_cnt_q;
  reg                   rr_first_q;
  wire acc_del = (rr_delay_i == 6'h00) ? level1_accept_i
                                       : acc_sr_q[rr_delay_i - 6'h01];
  wire [`TRP_LEN_W-1:0] len_eff = (rr_length_i == 3'h0) ? 3'h1 :
    (rr_length_i > `TRP_LEN_MAX) ? `TRP_LEN_MAX : rr_length_i;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      acc_sr_q   <= 64'h0;
      rr_cnt_q   <= 3'h0;
      rr_first_q <= 1'b0;
    end else if (ce_i) begin
      acc_sr_q   <= {acc_sr_q[62:0], level1_accept_i};
      rr_first_q <= acc_del;
      if (acc_del)
        rr_cnt_q <= len_eff;
      else if (rr_cnt_q != 3'h0)
        rr_cnt_q <= rr_cnt_q - 3'h1;
    end
  end
  assign readout_request_pulse_o = (rr_cnt_q != 3'h0);

  // ==========================================================
  // derandomising fifos; one slice word per request tick, one roi word per event
  reg [SW-1:0]    sfifo_q [0:DEP-1];
  reg [ROIPW-1:0] rfifo_q [0:DEP-1];
  reg [FIFO_AW:0] s_wr_q, s_rd_q, r_wr_q, r_rd_q;
  reg [DEP-1:0]   s_last_q;
  wire s_full  = (s_wr_q - s_rd_q) == DEP_N;
  wire r_full  = (r_wr_q - r_rd_q) == DEP_N;
  wire [FIFO_AW:0] s_prev = s_wr_q - 1'b1;
  wire s_empty = (s_wr_q == s_rd_q);
  wire r_empty = (r_wr_q == r_rd_q);
  wire s_wr = ce_i & readout_request_pulse_o;
  wire r_wr = ce_i & rr_first_q;
  wire s_pop, r_pop;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_wr_q <= {(FIFO_AW+1){1'b0}};
      r_wr_q <= {(FIFO_AW+1){1'b0}};
      slice_overflow_o <= 1'b0;
      roi_overflow_o   <= 1'b0;
    end else begin
      if (s_wr && !s_full) begin
        sfifo_q[s_wr_q[FIFO_AW-1:0]]  <= spipe_out;
        s_last_q[s_wr_q[FIFO_AW-1:0]] <= (rr_cnt_q == 3'h1);
        s_wr_q <= s_wr_q + 1'b1;
      end
      if (s_wr && s_full)
        slice_overflow_o <= 1'b1;
      // a dropped final word still closes its event, else two events would merge
      if (s_wr && s_full && rr_cnt_q == 3'h1)
        s_last_q[s_prev[FIFO_AW-1:0]] <= 1'b1;
      if (r_wr && !r_full) begin
        rfifo_q[r_wr_q[FIFO_AW-1:0]] <= rpipe_out;
        r_wr_q <= r_wr_q + 1'b1;
      end
      if (r_wr && r_full)
        roi_overflow_o <= 1'b1;
    end
  end

  // ==========================================================
  // slice serialiser: 66 payload bits plus parity per slice per stream
  reg [1:0]           s_st_q;
  reg [`TRP_CNT_W-1:0] s_bit_q;
  reg [SW-1:0]        s_sh_q;
  reg [`TRP_STREAMS-1:0] s_par_q;
  reg                 s_lastw_q;
  assign s_pop = ce_i && !s_empty &&
    ((s_st_q == S_IDLE) ||
     (s_st_q == S_SEND && s_bit_q == `TRP_SLICE_BITS-1 && !s_lastw_q));
  wire [SW-1:0] s_head = sfifo_q[s_rd_q[FIFO_AW-1:0]];
  integer k;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_st_q <= S_IDLE;
      s_bit_q <= 8'h0;
      s_rd_q <= {(FIFO_AW+1){1'b0}};
      s_lastw_q <= 1'b0;
      slice_serial_o <= 16'h0;
      slice_busy_o <= 1'b0;
    end else if (ce_i) begin
      if (s_pop) begin
        s_rd_q    <= s_rd_q + 1'b1;
        s_lastw_q <= s_last_q[s_rd_q[FIFO_AW-1:0]];
        s_sh_q    <= s_head;
        for (k = 0; k < `TRP_STREAMS; k = k + 1)
          s_par_q[k] <= odd_par({{(SW-`TRP_SLICE_PAY){1'b0}},
                                 s_head[k*`TRP_SLICE_PAY +: `TRP_SLICE_PAY]});
        s_st_q  <= S_SEND;
        s_bit_q <= 8'h0;
      end
      case (s_st_q)
        S_IDLE: begin
          slice_serial_o <= 16'h0;
        end
        S_SEND: begin
          // busy rises together with bit 0, never ahead of it
          slice_busy_o <= 1'b1;
          for (k = 0; k < `TRP_STREAMS; k = k + 1)
            slice_serial_o[k] <= (s_bit_q == `TRP_SLICE_PAY) ? s_par_q[k] :
              s_sh_q[k*`TRP_SLICE_PAY + s_bit_q];
          if (!s_pop)
            s_bit_q <= s_bit_q + 8'h1;
          if (!s_pop && s_bit_q == `TRP_SLICE_BITS-1) begin
            s_st_q  <= S_GAP;
            s_bit_q <= 8'h0;
          end
        end
        S_GAP: begin
          slice_serial_o <= 16'h0;
          slice_busy_o   <= 1'b0;
          s_bit_q <= s_bit_q + 8'h1;
          if (s_bit_q == GAP_TICKS-1)
            s_st_q <= S_IDLE;
        end
        default: s_st_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // roi serialiser: 44 payload bits plus odd parity per lane
  reg [1:0]            r_st_q;
  reg [`TRP_CNT_W-1:0] r_bit_q;
  reg [ROIPW-1:0]      r_sh_q;
  reg [3:0]            r_par_q;
  assign r_pop = ce_i && !r_empty && (r_st_q == S_IDLE);
  wire [ROIPW-1:0] r_head = rfifo_q[r_rd_q[FIFO_AW-1:0]];
  integer m;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      r_st_q <= S_IDLE;
      r_bit_q <= 8'h0;
      r_rd_q <= {(FIFO_AW+1){1'b0}};
      r_par_q <= 4'h0;
      roi_serial_o <= 4'h0;
      roi_busy_o <= 1'b0;
    end else if (ce_i) begin
      case (r_st_q)
        S_IDLE: begin
          roi_serial_o <= 4'h0;
          if (r_pop) begin
            r_rd_q <= r_rd_q + 1'b1;
            r_sh_q <= r_head;
            for (m = 0; m < ROIL; m = m + 1)
              r_par_q[m] <= odd_par({{(SW-`TRP_ROI_PAY){1'b0}},
                                     r_head[m*`TRP_ROI_PAY +: `TRP_ROI_PAY]});
            r_st_q  <= S_SEND;
            r_bit_q <= 8'h0;
          end
        end
        S_SEND: begin
          roi_busy_o <= 1'b1;
          for (m = 0; m < ROIL; m = m + 1)
            roi_serial_o[m] <= (r_bit_q == `TRP_ROI_PAY) ? r_par_q[m] :
              r_sh_q[m*`TRP_ROI_PAY + r_bit_q];
          r_bit_q <= r_bit_q + 8'h1;
          if (r_bit_q == `TRP_ROI_BITS-1) begin
            r_st_q  <= S_GAP;
            r_bit_q <= 8'h0;
          end
        end
        S_GAP: begin
          roi_serial_o <= 4'h0;
          roi_busy_o   <= 1'b0;
          r_bit_q <= r_bit_q + 8'h1;
          if (r_bit_q == GAP_TICKS-1)
            r_st_q <= S_IDLE;
        end
        default: r_st_q <= S_IDLE;
      endcase
    end
  end
endmodule // trp_readout

// ### trp_readout_assertions.sv
// Purpose: port checker for the readout block
// Assumes: one clock, synchronous high reset
// Notes: packet sizes are judged from busy run lengths
`timescale 1ns/1ps
// ========================================
// checks
module trp_readout_chk #(
  parameter FCAL      = 0,
  parameter GAP_TICKS = 20
) (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        level1_accept_i,
  input wire [5:0]  rr_delay_i,
  input wire [2:0]  rr_length_i,
  input wire        readout_request_pulse_o,
  input wire [15:0] slice_serial_o,
  input wire [3:0]  roi_serial_o,
  input wire        slice_busy_o,
  input wire        roi_busy_o,
  input wire        slice_overflow_o
);
  reg [8:0] s_run_q;
  reg [5:0] r_run_q;
  reg [4:0] s_idle_q;
  reg       r_par_q;
  wire      rp = readout_request_pulse_o;
  // idle count saturates so a first packet after reset is not a gap fault
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_run_q  <= 9'h000;
      r_run_q  <= 6'h00;
      s_idle_q <= 5'h1F;
      r_par_q  <= 1'b0;
    end else begin
      s_run_q  <= slice_busy_o ? s_run_q + 9'h001 : 9'h000;
      r_run_q  <= roi_busy_o ? r_run_q + 6'h01 : 6'h00;
      s_idle_q <= slice_busy_o ? 5'h00 : (s_idle_q == 5'h1F ? 5'h1F : s_idle_q + 5'h01);
      r_par_q  <= roi_busy_o ? r_par_q ^ roi_serial_o[0] : 1'b0;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  dly_zero_a: assert property (
    level1_accept_i && rr_delay_i == 6'h00 && !rp |=> rp) else $error("request late");
  dly_max_a: assert property (
    level1_accept_i && rr_delay_i == 6'h3F |-> ##64 rp) else $error("request not at 64");
  len_five_a: assert property (
    $rose(rp) && rr_length_i == 3'h5 |-> rp[*5] ##1 !rp) else $error("request not 5");
  len_one_a: assert property (
    $rose(rp) && rr_length_i == 3'h1 |=> !rp) else $error("request not 1");
  start_now_a: assert property (
    $rose(rp) && !slice_busy_o && s_idle_q >= GAP_TICKS |-> ##3 slice_busy_o)
    else $error("packet start delayed");
  slice_len_a: assert property (
    $fell(slice_busy_o) |-> s_run_q != 0 && s_run_q % 67 == 0 && s_run_q <= 335)
    else $error("slice packet size");
  roi_len_a: assert property (
    $fell(roi_busy_o) |-> r_run_q == 45 && r_par_q) else $error("roi packet size or parity");
  gap_a: assert property (
    $rose(slice_busy_o) |-> s_idle_q >= GAP_TICKS) else $error("gap too short");
  quiet_a: assert property (
    !slice_busy_o |-> slice_serial_o == 16'h0000) else $error("bits outside packet");
  sticky_a: assert property (
    slice_overflow_o |=> slice_overflow_o) else $error("overflow cleared");
  lanes_a: assert property (
    FCAL == 0 |-> roi_serial_o[3:2] == 2'h0) else $error("forward lanes driven");
endmodule // trp_readout_chk

bind trp_readout trp_readout_chk #(.FCAL(FCAL), .GAP_TICKS(GAP_TICKS)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .level1_accept_i(level1_accept_i),
  .rr_delay_i(rr_delay_i), .rr_length_i(rr_length_i),
  .readout_request_pulse_o(readout_request_pulse_o), .slice_serial_o(slice_serial_o),
  .roi_serial_o(roi_serial_o), .slice_busy_o(slice_busy_o), .roi_busy_o(roi_busy_o),
  .slice_overflow_o(slice_overflow_o));
